// ### logic/acs_dev_end.sv
/*
  Configuration end of the dual converter: serial register port, soft reset
  and status register, and the pin-strap decoder.
  Assumes the serial pins are synchronous to core_clk_in and that the serial
  clock runs far slower than the core clock so each edge is seen.
*/
// Notes on behaviour
// - mode pin low: serial port; high: straps
// - select low: take data on clock rise
// - select high: ignore data and clock
// - host raises select after every cycle
// - cycle is control byte then data byte
// - first bit: 0 write, 1 read
// - next seven bits are register address
// - last eight bits carry data byte
// - address and data go MSB first
// - read: D7 driven after fall after eighth rise
// - host may release data after eighth rise
// - further read bits driven on clock falls
// - host captures read bits on rise
// - writing 5Ah to 0Ah resets all registers
// - reading 0Ah returns status byte
// - format strap: low twos, supply offset, open gray
// - divider strap: low 1, supply 2, open 4
// - bus strap: low dual, supply mux A, open B
// - strap mode: power-down fall resets registers
// - status bit5 ROM busy, bit4 ROM good
// - status bit0 duty-cycle DLL locked
`timescale 1ns/1ps
module acs_dev_end (
  input wire logic core_clk_in,                                // Core clock, 125 MHz
  input wire logic arst_n_in,                                  // Asynchronous reset, active low
  acs_if.dev link,                                             // Pins toward the host
  input wire logic rom_busy_in,                                // ROM load in progress
  input wire logic rom_ok_in,                                  // ROM load done, checksum good
  input wire logic dll_lock_in,                                // Duty-cycle DLL locked
  output logic [acs_pkg::NUM_REGS*acs_pkg::DATA_W-1:0] ctrl_regs_out, // Registers 00h..08h
  output logic strap_mode_out,                                 // Straps in control
  output acs_pkg::acs_fmt_t fmt_out,                           // Strap output format
  output acs_pkg::acs_div_t div_out,                           // Strap clock divider
  output acs_pkg::acs_bus_t bus_out,                           // Strap bus arrangement
  output logic soft_reset_out                                  // Register reset pulse
);
  import acs_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_CMD = 5'h02,
    S_WR = 5'h04,
    S_RD = 5'h08,
    S_DONE = 5'h10
  } acs_ser_state_t;

  acs_ser_state_t state_reg;
  acs_ser_state_t state_next;
  logic sclk_prev_reg;
  logic pd_prev_reg;
  logic [CNT_W-1:0] bit_cnt_reg;
  logic [CYCLE_BITS-2:0] shift_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] rd_shift_reg;
  logic sdio_o_reg;
  logic sdio_oe_reg;
  logic [DATA_W-1:0] regs_reg [NUM_REGS];
  logic serial_mode;
  logic active;
  logic rise;
  logic fall;
  logic cmd_done;
  logic wr_commit;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_value;
  logic reg_clear;

  assign serial_mode = ~link.prog_mode_select_n;
  assign active = serial_mode & ~link.sel_n;
  assign rise = active & link.sclk & ~sclk_prev_reg;
  assign fall = active & ~link.sclk & sclk_prev_reg;
  assign cmd_done = (state_reg == S_CMD) && rise && (bit_cnt_reg == LAST_CMD_BIT);
  assign cmd_addr = {shift_reg[ADDR_W-2:0], link.serial_data_io};
  assign wr_data = {shift_reg[DATA_W-2:0], link.serial_data_io};
  assign wr_commit = (state_reg == S_WR) && rise && (bit_cnt_reg == LAST_CYCLE_BIT);
  assign soft_reset_out = wr_commit && (addr_reg == SOFT_RST_ADDR) && (wr_data == SOFT_RST_KEY);
  assign reg_clear = soft_reset_out | (~serial_mode & pd_prev_reg & ~link.power_down_pin);

  // Read value for the address just received
  always_comb
  begin
    rd_value = UNMAPPED_READ;
    if (cmd_addr == SOFT_RST_ADDR)
    begin
      rd_value = STAT_FIXED;
      rd_value[STAT_ROM_BUSY_BIT] = rom_busy_in;
      rd_value[STAT_ROM_OK_BIT] = rom_ok_in;
      rd_value[STAT_DLL_LOCK_BIT] = dll_lock_in;
    end
    else if (cmd_addr <= LAST_REG_ADDR)
    begin
      rd_value = regs_reg[cmd_addr[3:0]];
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sclk_prev_reg <= 1'b0;
      pd_prev_reg <= 1'b0;
    end
    else
    begin
      sclk_prev_reg <= link.sclk;
      pd_prev_reg <= link.power_down_pin;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE:
      begin
        if (active)
          state_next = S_CMD;
      end
      S_CMD:
      begin
        if (!active)
          state_next = S_IDLE;
        else if (cmd_done)
          state_next = shift_reg[ADDR_W-1] == DIR_READ ? S_RD : S_WR;
      end
      S_WR, S_RD:
      begin
        if (!active)
          state_next = S_IDLE;
        else if (rise && bit_cnt_reg == LAST_CYCLE_BIT)
          state_next = S_DONE;
      end
      S_DONE:
      begin
        if (!active)
          state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state_reg <= S_IDLE;
    else
      state_reg <= state_next;
  end

  // Bit counter and input shifter; the counter is cleared whenever the select is high, the shifter keeps its value
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      bit_cnt_reg <= '0;
      shift_reg <= '0;
    end
    else if (!active)
    begin
      bit_cnt_reg <= '0;
    end
    else if (rise && state_reg != S_DONE)
    begin
      shift_reg <= {shift_reg[CYCLE_BITS-3:0], link.serial_data_io};
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      addr_reg <= '0;
    else if (cmd_done)
      addr_reg <= cmd_addr;
  end

  // Read shifter: D7 goes out on the first fall after the eighth rise
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rd_shift_reg <= '0;
      sdio_o_reg <= 1'b0;
      sdio_oe_reg <= 1'b0;
    end
    else if (!active)
    begin
      sdio_oe_reg <= 1'b0;
    end
    else if (cmd_done)
    begin
      rd_shift_reg <= rd_value;
    end
    else if (state_reg == S_RD && fall)
    begin
      sdio_o_reg <= rd_shift_reg[DATA_W-1];
      sdio_oe_reg <= 1'b1;
      rd_shift_reg <= {rd_shift_reg[DATA_W-2:0], 1'b0};
    end
  end

  assign link.dev_sdio_o = sdio_o_reg;
  assign link.dev_sdio_oe = sdio_oe_reg;

  // Control registers, one per address
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++)
    begin : g_reg
      always_ff @(posedge core_clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
          regs_reg[gi] <= REG_DEFAULT[gi];
        else if (reg_clear)
          regs_reg[gi] <= REG_DEFAULT[gi];
        else if (wr_commit && addr_reg == ADDR_W'(gi))
          regs_reg[gi] <= wr_data;
      end
      assign ctrl_regs_out[gi*DATA_W +: DATA_W] = regs_reg[gi];
    end
  endgenerate

  // Strap decode, updated while straps are in control, held while the serial port is in control
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      strap_mode_out <= 1'b0;
      fmt_out <= ACS_FMT_TWOS;
      div_out <= ACS_DIV_1;
      bus_out <= ACS_BUS_DUAL;
    end
    else
    begin
      strap_mode_out <= ~serial_mode;
      if (!serial_mode)
      begin
        unique case (link.fmt_strap)
          ACS_STRAP_LOW: fmt_out <= ACS_FMT_TWOS;
          ACS_STRAP_SUPPLY: fmt_out <= ACS_FMT_OFFSET;
          default: fmt_out <= ACS_FMT_GRAY;
        endcase
        unique case (link.div_strap)
          ACS_STRAP_LOW: div_out <= ACS_DIV_1;
          ACS_STRAP_SUPPLY: div_out <= ACS_DIV_2;
          default: div_out <= ACS_DIV_4;
        endcase
        unique case (link.output_bus_strap)
          ACS_STRAP_LOW: bus_out <= ACS_BUS_DUAL;
          ACS_STRAP_SUPPLY: bus_out <= ACS_BUS_MUX_A;
          default: bus_out <= ACS_BUS_MUX_B;
        endcase
      end
    end
  end
endmodule

// ### logic/acs_host_end.sv
/*
  Host controller end: runs one 16-bit serial read or write cycle per request,
  making the serial clock from the core clock, and drives the mode and strap
  pins from its user side.
  Assumes the configuration end shares the core clock.
*/
`timescale 1ns/1ps
module acs_host_end (
  input wire logic core_clk_in,                      // Core clock, 125 MHz
  input wire logic arst_n_in,                        // Asynchronous reset, active low
  acs_if.host link,                                  // Pins toward the device
  input wire logic strap_mode_in,                    // 1 selects pin-strap mode
  input wire logic power_down_in,                    // Power-down pin level
  input acs_pkg::acs_strap_t fmt_strap_in,           // Format strap level
  input acs_pkg::acs_strap_t div_strap_in,           // Divider strap level
  input acs_pkg::acs_strap_t bus_strap_in,           // Output bus strap level
  input wire logic cmd_valid_in,                     // Request a cycle
  output logic cmd_ready_out,                        // Ready for a request
  input wire logic cmd_read_in,                      // 1 read, 0 write
  input wire logic [acs_pkg::ADDR_W-1:0] cmd_addr_in, // Register address
  input wire logic [acs_pkg::DATA_W-1:0] cmd_wdata_in, // Write data
  output logic rsp_valid_out,                        // Cycle finished pulse
  output logic [acs_pkg::DATA_W-1:0] rsp_rdata_out   // Read data
);
  import acs_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_LOW = 4'h2,
    H_HIGH = 4'h4,
    H_GAP = 4'h8
  } acs_host_state_t;

  acs_host_state_t state_reg;
  logic [HALF_CNT_W-1:0] half_reg;
  logic [CNT_W-1:0] bit_reg;
  logic [CYCLE_BITS-1:0] tx_reg;
  logic [DATA_W-1:0] rx_reg;
  logic read_reg;
  logic sel_n_reg;
  logic sclk_reg;
  logic sdo_reg;
  logic sdo_oe_reg;
  logic half_done;

  assign half_done = half_reg == HALF_CNT_W'(SCLK_HALF_CYC - 1);
  assign cmd_ready_out = (state_reg == H_IDLE) && !strap_mode_in;

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_reg <= H_IDLE;
      half_reg <= '0;
      bit_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
      read_reg <= 1'b0;
      sel_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      sdo_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end
    else
    begin
      rsp_valid_out <= 1'b0;
      half_reg <= half_done ? '0 : half_reg + 4'h1;
      unique case (state_reg)
        H_IDLE:
        begin
          half_reg <= '0;
          if (cmd_valid_in && cmd_ready_out)
          begin
            tx_reg <= {cmd_read_in, cmd_addr_in, cmd_wdata_in};
            read_reg <= cmd_read_in;
            sel_n_reg <= 1'b0;
            sdo_reg <= cmd_read_in;
            sdo_oe_reg <= 1'b1;
            bit_reg <= '0;
            state_reg <= H_LOW;
          end
        end
        H_LOW:
        begin
          if (half_done)
          begin
            sclk_reg <= 1'b1;
            state_reg <= H_HIGH;
            if (read_reg && bit_reg > LAST_CMD_BIT)
              rx_reg <= {rx_reg[DATA_W-2:0], link.serial_data_io};
          end
        end
        H_HIGH:
        begin
          if (read_reg && bit_reg == LAST_CMD_BIT)
            sdo_oe_reg <= 1'b0;
          if (half_done)
          begin
            sclk_reg <= 1'b0;
            if (bit_reg == LAST_CYCLE_BIT)
            begin
              sel_n_reg <= 1'b1;
              sdo_oe_reg <= 1'b0;
              rsp_valid_out <= 1'b1;
              rsp_rdata_out <= rx_reg;
              state_reg <= H_GAP;
            end
            else
            begin
              bit_reg <= bit_reg + 5'h01;
              tx_reg <= {tx_reg[CYCLE_BITS-2:0], 1'b0};
              sdo_reg <= tx_reg[CYCLE_BITS-2];
              state_reg <= H_LOW;
            end
          end
        end
        H_GAP:
        begin
          if (half_done)
            state_reg <= H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      link.prog_mode_select_n <= 1'b0;
    else
      link.prog_mode_select_n <= strap_mode_in;
  end

  assign link.sel_n = sel_n_reg;
  assign link.sclk = sclk_reg;
  assign link.host_sdio_o = sdo_reg;
  assign link.host_sdio_oe = sdo_oe_reg;
  assign link.power_down_pin = power_down_in;
  assign link.fmt_strap = fmt_strap_in;
  assign link.div_strap = div_strap_in;
  assign link.output_bus_strap = bus_strap_in;
endmodule

// ### shared/acs_if.sv
/*
  Pins between the host controller end and the converter's configuration end.
  The shared data pin is resolved here from both output enables; an undriven
  pin reads high as if pulled up. Strap levels are carried as three-level codes.
*/
`timescale 1ns/1ps
interface acs_if;
  import acs_pkg::*;
  logic prog_mode_select_n;
  logic sel_n;
  logic sclk;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic serial_data_io;
  logic power_down_pin;
  acs_strap_t fmt_strap;
  acs_strap_t div_strap;
  acs_strap_t output_bus_strap;

  assign serial_data_io = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);

  modport host (
    output prog_mode_select_n, sel_n, sclk, host_sdio_o, host_sdio_oe,
    output power_down_pin, fmt_strap, div_strap, output_bus_strap,
    input serial_data_io
  );
  modport dev (
    input prog_mode_select_n, sel_n, sclk, serial_data_io,
    input power_down_pin, fmt_strap, div_strap, output_bus_strap,
    output dev_sdio_o, dev_sdio_oe
  );
endinterface

// ### shared/acs_pkg.sv
/*
  Shared constants and types for the converter configuration port: the serial
  cycle layout, the register map, the status byte layout, the strap codes and
  the serial clock timing.
  Assumes both ends run on one 125 MHz core clock.
*/
package acs_pkg;
  localparam int CORE_PERIOD_NS = 8;
  localparam int SCLK_HALF_NS = 32;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int HALF_CNT_W = 4;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CYCLE_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] LAST_CMD_BIT = 5'h07;
  localparam logic [CNT_W-1:0] LAST_CYCLE_BIT = 5'h0F;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  localparam int NUM_REGS = 9;
  localparam logic [ADDR_W-1:0] LAST_REG_ADDR = 7'h08;
  localparam logic [ADDR_W-1:0] SOFT_RST_ADDR = 7'h0A;
  localparam logic [DATA_W-1:0] SOFT_RST_KEY = 8'h5A;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
  localparam logic [DATA_W-1:0] REG_DEFAULT [NUM_REGS] = '{
    8'h03, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  localparam int STAT_ROM_BUSY_BIT = 5;
  localparam int STAT_ROM_OK_BIT = 4;
  localparam int STAT_DLL_LOCK_BIT = 0;
  localparam logic [DATA_W-1:0] STAT_FIXED = 8'h04;

  typedef enum logic [1:0] {
    ACS_STRAP_LOW = 2'h0,
    ACS_STRAP_SUPPLY = 2'h1,
    ACS_STRAP_OPEN = 2'h2
  } acs_strap_t;

  typedef enum logic [1:0] {
    ACS_FMT_TWOS = 2'h0,
    ACS_FMT_OFFSET = 2'h1,
    ACS_FMT_GRAY = 2'h2
  } acs_fmt_t;

  typedef enum logic [1:0] {
    ACS_DIV_1 = 2'h0,
    ACS_DIV_2 = 2'h1,
    ACS_DIV_4 = 2'h2
  } acs_div_t;

  typedef enum logic [1:0] {
    ACS_BUS_DUAL = 2'h0,
    ACS_BUS_MUX_A = 2'h1,
    ACS_BUS_MUX_B = 2'h2
  } acs_bus_t;
endpackage

// ### verif/acs_assertions.sv
/*
  Checker on the serial pins between the host end and the configuration end.
  Assumes one core clock and is instantiated beside the joining interface.
*/
`timescale 1ns/1ps
module acs_assertions
  import acs_pkg::*;
(
  input wire logic core_clk_in,        // Core clock
  input wire logic arst_n_in,          // Reset, active low
  input wire logic prog_mode_select_n, // Mode pin
  input wire logic sel_n,              // Serial select
  input wire logic sclk,               // Serial clock
  input wire logic host_sdio_oe,       // Host drives data pin
  input wire logic dev_sdio_o,         // Device data out
  input wire logic dev_sdio_oe,        // Device drives data pin
  input wire logic serial_data_io      // Resolved data pin
);
  logic sclk_reg;
  logic rw_reg;
  logic [4:0] rises_reg;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      sclk_reg <= 1'b0;
    else
      sclk_reg <= sclk;
  end

  // Rising serial clock edges seen in the current frame
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rises_reg <= 5'h00;
    else if (sel_n)
      rises_reg <= 5'h00;
    else if (sclk && !sclk_reg)
      rises_reg <= rises_reg + 5'h01;
  end

  // Direction bit of the current frame
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rw_reg <= 1'b0;
    else if (!sel_n && sclk && !sclk_reg && rises_reg == 5'h00)
      rw_reg <= serial_data_io;
  end

  chk_no_contention: assert property (!(host_sdio_oe && dev_sdio_oe))
    else $error("both ends drive the data pin");
  chk_idle_clock_low: assert property (sel_n |-> !sclk)
    else $error("serial clock high while deselected");
  chk_sclk_high_len: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  chk_strap_mode_quiet: assert property (prog_mode_select_n |-> !dev_sdio_oe)
    else $error("device drives data pin in strap mode");
  chk_dev_release_sel: assert property (sel_n [*2] |-> !dev_sdio_oe)
    else $error("device still drives after deselect");
  chk_write_no_drive: assert property (dev_sdio_oe |-> rw_reg == DIR_READ)
    else $error("device drives data pin on a write");
  chk_read_turn_start: assert property ($rose(dev_sdio_oe) |-> rises_reg == 5'h08 && !sclk)
    else $error("read data driven at wrong bit");
  chk_read_bit_stable: assert property (sclk && $past(sclk) && dev_sdio_oe |-> $stable(dev_sdio_o))
    else $error("read data changed while clock high");
  chk_host_lets_go: assert property (rw_reg && rises_reg == 5'h08 && !sclk |-> !host_sdio_oe)
    else $error("host still drives in read data phase");
  chk_frame_sixteen: assert property ($rose(sel_n) |-> rises_reg == 5'h10)
    else $error("frame did not have sixteen clock rises");
endmodule

// ### verif/adc_config_serial_port_tb.sv
/*
  Testbench: host end and configuration end joined by the interface, with the
  pin checker beside it. Both user sides are driven on the falling edge.
*/
`timescale 1ns/1ps
module adc_config_serial_port_tb;
  import acs_pkg::*;
  logic core_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic strap_mode = 1'b0;
  logic power_down = 1'b0;
  acs_strap_t fmt_s = ACS_STRAP_LOW;
  acs_strap_t div_s = ACS_STRAP_LOW;
  acs_strap_t bus_s = ACS_STRAP_LOW;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [DATA_W-1:0] cmd_wdata = '0;
  logic rom_busy = 1'b0;
  logic rom_ok = 1'b0;
  logic dll_lock = 1'b0;
  logic cmd_ready, rsp_valid, strap_mode_o, soft_rst;
  logic [DATA_W-1:0] rsp_rdata;
  logic [NUM_REGS*DATA_W-1:0] regs, defaults, exp_regs;
  acs_fmt_t fmt_o;
  acs_div_t div_o;
  acs_bus_t bus_o;
  logic [15:0] wire_bits = '0;
  logic [4:0] wire_rises = '0;
  logic sclk_q = 1'b0;
  int fails = 0;
  int num_checks = 0;
  int pulses = 0;

  acs_if link_if();
  always #4 core_clk_in = ~core_clk_in;

  acs_host_end acs_host_end_i (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .link(link_if),
    .strap_mode_in(strap_mode), .power_down_in(power_down), .fmt_strap_in(fmt_s), .div_strap_in(div_s),
    .bus_strap_in(bus_s), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_read_in(cmd_read),
    .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata), .rsp_valid_out(rsp_valid), .rsp_rdata_out(rsp_rdata));
  acs_dev_end acs_dev_end_i (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .link(link_if),
    .rom_busy_in(rom_busy), .rom_ok_in(rom_ok), .dll_lock_in(dll_lock), .ctrl_regs_out(regs),
    .strap_mode_out(strap_mode_o), .fmt_out(fmt_o), .div_out(div_o), .bus_out(bus_o), .soft_reset_out(soft_rst));
  acs_assertions acs_assertions_i (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .prog_mode_select_n(link_if.prog_mode_select_n), .sel_n(link_if.sel_n), .sclk(link_if.sclk),
    .host_sdio_oe(link_if.host_sdio_oe), .dev_sdio_o(link_if.dev_sdio_o), .dev_sdio_oe(link_if.dev_sdio_oe),
    .serial_data_io(link_if.serial_data_io));

  // Pin monitor: bits on the data pin at each serial clock rise
  always @(posedge core_clk_in)
  begin
    sclk_q <= link_if.sclk;
    if (!link_if.sel_n && link_if.sclk && !sclk_q)
    begin
      wire_bits <= {wire_bits[14:0], link_if.serial_data_io};
      wire_rises <= wire_rises + 5'h01;
    end
    if (soft_rst === 1'b1)
      pulses <= pulses + 1;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(inout int n);
    @(negedge core_clk_in);
    n++;
    if (n > 200)
    begin
      $display("timeout waiting for the host end");
      fails++;
      finish_test();
    end
  endtask

  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1)
      step(n);
    wire_rises = 5'h00;
    cmd_read = rd;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(negedge core_clk_in);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1)
      step(n);
    check("rise count", wire_rises, 5'h10);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    xfer(DIR_WRITE, a, d);
    check("write bits", wire_bits, {DIR_WRITE, a, d});
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    xfer(DIR_READ, a, 8'h00);
    check("read data", rsp_rdata, exp);
    check("read bits", wire_bits, {DIR_READ, a, exp});
  endtask

  task automatic t_reset();
    check("reset regs", regs, defaults);
    check("reset straps", {strap_mode_o, fmt_o, div_o, bus_o}, 7'h00);
    $display("done reset values");
  endtask

  task automatic t_regs();
    logic [DATA_W-1:0] d;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      d = {i[3:0], 4'h9};
      exp_regs[8*i+:8] = d;
      wr(ADDR_W'(i), d);
      check("regs after write", regs, exp_regs);
    end
    for (int i = 0; i < NUM_REGS; i++)
      rd(ADDR_W'(i), exp_regs[8*i+:8]);
    $display("done register write and read");
  endtask

  task automatic t_unmapped();
    wr(7'h09, 8'hFF);
    wr(7'h7F, 8'hFF);
    wr(SOFT_RST_ADDR, 8'h33);
    check("regs unchanged", regs, exp_regs);
    check("no reset pulse", pulses, 0);
    rd(7'h0B, UNMAPPED_READ);
    $display("done unmapped and wrong key");
  endtask

  // Mode pin blips high over the first rise, so the device sees a 15-rise frame
  task automatic t_cut();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1)
      step(n);
    cmd_read = DIR_WRITE;
    cmd_addr = 7'h01;
    cmd_wdata = 8'h3C;
    cmd_valid = 1'b1;
    @(negedge core_clk_in);
    cmd_valid = 1'b0;
    strap_mode = 1'b1;
    repeat (6) @(negedge core_clk_in);
    strap_mode = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1)
      step(n);
    check("cut frame dropped", regs, exp_regs);
    check("no pulse on cut frame", pulses, 0);
    rd(7'h01, exp_regs[15:8]);
    $display("done cut frame");
  endtask

  task automatic t_status();
    logic [2:0] k;
    for (int i = 0; i < 8; i++)
    begin
      k = i[2:0];
      {rom_busy, rom_ok, dll_lock} = k;
      rd(SOFT_RST_ADDR, {2'h0, k[2], k[1], 3'h2, k[0]});
    end
    $display("done status byte");
  endtask

  task automatic t_soft();
    wr(SOFT_RST_ADDR, SOFT_RST_KEY);
    exp_regs = defaults;
    check("soft reset regs", regs, defaults);
    check("one reset pulse", pulses, 1);
    $display("done soft reset");
  endtask

  task automatic t_strap();
    acs_fmt_t ft[3] = '{ACS_FMT_TWOS, ACS_FMT_OFFSET, ACS_FMT_GRAY};
    acs_div_t dt[3] = '{ACS_DIV_1, ACS_DIV_2, ACS_DIV_4};
    acs_bus_t bt[3] = '{ACS_BUS_DUAL, ACS_BUS_MUX_A, ACS_BUS_MUX_B};
    wr(7'h02, 8'hA6);
    exp_regs[23:16] = 8'hA6;
    power_down = 1'b1;
    repeat (2) @(negedge core_clk_in);
    power_down = 1'b0;
    repeat (2) @(negedge core_clk_in);
    check("fall ignored in serial mode", regs, exp_regs);
    strap_mode = 1'b1;
    power_down = 1'b1;
    repeat (6) @(negedge core_clk_in);
    check("ready in strap mode", cmd_ready, 1'b0);
    check("strap mode out", strap_mode_o, 1'b1);
    check("regs before fall", regs, exp_regs);
    for (int c = 0; c < 3; c++)
    begin
      fmt_s = acs_strap_t'(c);
      div_s = acs_strap_t'((c + 1) % 3);
      bus_s = acs_strap_t'((c + 2) % 3);
      repeat (4) @(negedge core_clk_in);
      check("format", fmt_o, ft[c]);
      check("divider", div_o, dt[(c + 1) % 3]);
      check("bus", bus_o, bt[(c + 2) % 3]);
    end
    power_down = 1'b0;
    repeat (4) @(negedge core_clk_in);
    check("regs after fall", regs, defaults);
    strap_mode = 1'b0;
    $display("done strap mode");
  endtask

  initial
  begin
    for (int i = 0; i < NUM_REGS; i++)
      defaults[8*i+:8] = REG_DEFAULT[i];
    exp_regs = defaults;
    repeat (20) @(negedge core_clk_in);
    arst_n_in = 1'b1;
    t_reset();
    t_regs();
    t_unmapped();
    t_cut();
    t_status();
    t_soft();
    t_strap();
    finish_test();
  end
endmodule
